// ### design/overrange_clock_out_mux.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "overrange_map.svh"

module overrange_clock_out_mux (
  input wire logic clk,
  input wire logic reset,
  input wire overrange_pkg::chan_samples_t samples,
  input wire logic synth_ref_clock_out,
  input wire logic synth_enable_pin,
  input wire logic power_down_pin,
  input wire logic [1:0] clock_out_select_straps,
  input wire logic [1:0] variant_straps,
  input wire overrange_pkg::reg_req_t reg_req,
  output logic [31:0] rd_data_q,
  output logic irq_q,
  output logic overrange_out_chan_a,
  output logic overrange_out_chan_b,
  output logic overrange_or_clock_out_c,
  output logic overrange_or_clock_out_d
);

  // ==========================================================
  // Clock pick shared by pins C and D
  function automatic logic pick_clock(input logic [1:0] sel, input logic r,
                                      input logic d2, input logic d4);
    case (sel)
      overrange_pkg::sel_ref: pick_clock = r;
      overrange_pkg::sel_div2: pick_clock = d2;
      overrange_pkg::sel_div4: pick_clock = d4;
      default: pick_clock = 1'b0;
    endcase
  endfunction : pick_clock

  // ==========================================================
  // Registers
  logic [8:0] threshold_q;
  logic [7:0] min_pulse_q;
  logic [4:0] clock_ctrl_q;
  logic [3:0] status_q;
  logic [3:0] status_d;
  logic [3:0] mask_q;
  overrange_pkg::variant_t variant_q;
  logic variant_taken_q;

  // ==========================================================
  // Internal signals
  logic [3:0] flag;
  logic [3:0] evt;
  logic [3:0] chan_on;
  logic [3:0] flag_gated;
  logic [8:0] chan_sample [4];
  logic ref_q;
  logic div2_q;
  logic div4_q;
  logic [1:0] c_sel;
  logic [1:0] d_sel;
  logic c_clock_on;
  logic d_clock_on;
  logic ovr_en;
  logic status_rd;

  assign chan_sample[0] = samples.a;
  assign chan_sample[1] = samples.b;
  assign chan_sample[2] = samples.c;
  assign chan_sample[3] = samples.d;

  // ==========================================================
  // Per-channel detectors
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      overrange_hold u_hold (
        .clk(clk),
        .reset(reset),
        .sample(chan_sample[gi]),
        .threshold(threshold_q),
        .min_pulse(min_pulse_q),
        .flag_q(flag[gi]),
        .event_o(evt[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Reference dividers
  ref_clock_div u_div (
    .clk(clk),
    .reset(reset),
    .ref_in(synth_ref_clock_out),
    .ref_q(ref_q),
    .div2_q(div2_q),
    .div4_q(div4_q)
  );

  // ==========================================================
  // Variant capture after reset release
  always_ff @(posedge clk) begin
    if (reset) begin
      variant_q <= overrange_pkg::variant_quad;
      variant_taken_q <= 1'b0;
    end else if (!variant_taken_q) begin
      variant_q <= overrange_pkg::variant_t'(variant_straps);
      variant_taken_q <= 1'b1;
    end
  end

  // ==========================================================
  // Channel availability per variant
  always_comb begin
    chan_on[0] = 1'b1;
    chan_on[1] = (variant_q == overrange_pkg::variant_quad) ||
                 (variant_q == overrange_pkg::variant_dual);
    chan_on[2] = (variant_q == overrange_pkg::variant_quad);
    chan_on[3] = (variant_q == overrange_pkg::variant_quad);
  end

  assign flag_gated = flag & chan_on & {4{!power_down_pin}};

  // ==========================================================
  // Clock selection
  assign ovr_en = clock_ctrl_q[`CTRL_OVR_EN_BIT];
  assign c_sel = ovr_en ? clock_ctrl_q[`CTRL_C_SEL_HI:`CTRL_C_SEL_LO]
                        : clock_out_select_straps;
  assign d_sel = ovr_en ? clock_ctrl_q[`CTRL_D_SEL_HI:`CTRL_D_SEL_LO] :
                 ((clock_out_select_straps != 2'h0) ? 2'h1 : 2'h0);
  assign c_clock_on = synth_enable_pin && !power_down_pin && (c_sel != 2'h0);
  assign d_clock_on = c_clock_on && (d_sel != 2'h0);

  // ==========================================================
  // Output pins
  always_ff @(posedge clk) begin
    if (reset) begin
      overrange_out_chan_a <= 1'b0;
      overrange_out_chan_b <= 1'b0;
    end else begin
      overrange_out_chan_a <= flag_gated[0];
      overrange_out_chan_b <= flag_gated[1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overrange_or_clock_out_c <= 1'b0;
    end else if (c_clock_on) begin
      overrange_or_clock_out_c <= pick_clock(c_sel, ref_q, div2_q, div4_q);
    end else begin
      overrange_or_clock_out_c <= flag_gated[2];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      overrange_or_clock_out_d <= 1'b0;
    end else if (d_clock_on) begin
      overrange_or_clock_out_d <= pick_clock(d_sel, ref_q, div2_q, div4_q);
    end else begin
      overrange_or_clock_out_d <= flag_gated[3];
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      threshold_q <= `RST_THRESHOLD;
      min_pulse_q <= `RST_MIN_PULSE;
      clock_ctrl_q <= `RST_CLOCK_CTRL;
      mask_q <= `RST_IRQ_MASK;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `OFS_THRESHOLD: threshold_q <= reg_req.wdata[8:0];
        `OFS_MIN_PULSE: min_pulse_q <= reg_req.wdata[7:0];
        `OFS_CLOCK_CTRL: clock_ctrl_q <= reg_req.wdata[4:0];
        `OFS_IRQ_MASK: mask_q <= reg_req.wdata[3:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status, read clears, set wins
  assign status_rd = reg_req.rd && (reg_req.addr == `OFS_IRQ_STATUS);
  assign status_d = (status_rd ? 4'h0 : status_q) | (evt & chan_on);

  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= 4'h0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  // ==========================================================
  // Register reads
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= 32'h0000_0000;
    end else if (reg_req.rd) begin
      rd_data_q <= 32'h0000_0000;
      case (reg_req.addr)
        `OFS_THRESHOLD: rd_data_q[8:0] <= threshold_q;
        `OFS_MIN_PULSE: rd_data_q[7:0] <= min_pulse_q;
        `OFS_CLOCK_CTRL: rd_data_q[4:0] <= clock_ctrl_q;
        `OFS_IRQ_STATUS: rd_data_q[3:0] <= status_q;
        `OFS_IRQ_MASK: rd_data_q[3:0] <= mask_q;
        `OFS_STATE: begin
          rd_data_q[`STATE_FLAGS_HI:`STATE_FLAGS_LO] <= flag_gated;
          rd_data_q[`STATE_SEL_HI:`STATE_SEL_LO] <= c_sel;
          rd_data_q[`STATE_C_CLK_BIT] <= c_clock_on;
          rd_data_q[`STATE_D_CLK_BIT] <= d_clock_on;
          rd_data_q[`STATE_VAR_HI:`STATE_VAR_LO] <= variant_q;
        end
        default: ;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Checks
  property p_flag_a;
    @(posedge clk) disable iff (reset)
    (samples.a > threshold_q && !power_down_pin) ##1 !power_down_pin
      |=> overrange_out_chan_a;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("channel A flag missing");

  property p_c_needs_enable;
    @(posedge clk) disable iff (reset)
    !synth_enable_pin |=> overrange_or_clock_out_c == $past(flag_gated[2]);
  endproperty
  a_c_needs_enable: assert property (p_c_needs_enable) else $error("clock without enable");

  property p_c_div2;
    @(posedge clk) disable iff (reset)
    (c_clock_on && c_sel == 2'h2) |=> overrange_or_clock_out_c == $past(div2_q);
  endproperty
  a_c_div2: assert property (p_c_div2) else $error("pin C not half rate");

  property p_c_div4;
    @(posedge clk) disable iff (reset)
    (c_clock_on && c_sel == 2'h3) |=> overrange_or_clock_out_c == $past(div4_q);
  endproperty
  a_c_div4: assert property (p_c_div4) else $error("pin C not quarter rate");

  property p_strap_clock;
    @(posedge clk) disable iff (reset)
    (!ovr_en && clock_out_select_straps != 2'h0 && synth_enable_pin && !power_down_pin)
      |-> c_clock_on;
  endproperty
  a_strap_clock: assert property (p_strap_clock) else $error("strap clock absent");

  property p_c_flag;
    @(posedge clk) disable iff (reset)
    (c_sel == 2'h0) |=> overrange_or_clock_out_c == $past(flag_gated[2]);
  endproperty
  a_c_flag: assert property (p_c_flag) else $error("pin C not carrying flag");

  property p_c_quad_only;
    @(posedge clk) disable iff (reset)
    (variant_q != overrange_pkg::variant_quad && !c_clock_on) |=> !overrange_or_clock_out_c;
  endproperty
  a_c_quad_only: assert property (p_c_quad_only) else $error("C flag in small variant");

  property p_b_single;
    @(posedge clk) disable iff (reset)
    (variant_q == overrange_pkg::variant_single) |=> !overrange_out_chan_b;
  endproperty
  a_b_single: assert property (p_b_single) else $error("B flag in single variant");

  property p_d_follows_c;
    @(posedge clk) disable iff (reset)
    !c_clock_on |=> overrange_or_clock_out_d == $past(flag_gated[3]);
  endproperty
  a_d_follows_c: assert property (p_d_follows_c) else $error("D clock without C clock");

  property p_flag_b;
    @(posedge clk) disable iff (reset)
    (samples.b > threshold_q && !power_down_pin && chan_on[1]) ##1
      (!power_down_pin && chan_on[1]) |=> overrange_out_chan_b;
  endproperty
  a_flag_b: assert property (p_flag_b) else $error("channel B flag missing");

  property p_c_ref;
    @(posedge clk) disable iff (reset)
    (c_clock_on && c_sel == 2'h1) |=> overrange_or_clock_out_c == $past(ref_q);
  endproperty
  a_c_ref: assert property (p_c_ref) else $error("pin C not reference copy");

  property p_d_ref;
    @(posedge clk) disable iff (reset)
    (d_clock_on && d_sel == 2'h1) |=> overrange_or_clock_out_d == $past(ref_q);
  endproperty
  a_d_ref: assert property (p_d_ref) else $error("pin D not reference copy");

  property p_d_div4;
    @(posedge clk) disable iff (reset)
    (d_clock_on && d_sel == 2'h3) |=> overrange_or_clock_out_d == $past(div4_q);
  endproperty
  a_d_div4: assert property (p_d_div4) else $error("pin D not quarter rate");

  property p_d_unsel;
    @(posedge clk) disable iff (reset)
    (c_clock_on && d_sel == 2'h0) |=> overrange_or_clock_out_d == $past(flag_gated[3]);
  endproperty
  a_d_unsel: assert property (p_d_unsel) else $error("pin D clock while unselected");

  property p_status_a;
    @(posedge clk) disable iff (reset)
    evt[0] |=> status_q[0];
  endproperty
  a_status_a: assert property (p_status_a) else $error("status A not set");

  property p_variant_hold;
    @(posedge clk) disable iff (reset)
    variant_taken_q |=> $stable(variant_q);
  endproperty
  a_variant_hold: assert property (p_variant_hold) else $error("variant changed");

  property p_c_off_pd;
    @(posedge clk) disable iff (reset)
    power_down_pin |=> !overrange_or_clock_out_c;
  endproperty
  a_c_off_pd: assert property (p_c_off_pd) else $error("pin C active in power down");

endmodule : overrange_clock_out_mux

`default_nettype wire

// ### design/overrange_hold.sv
`timescale 1ns/100ps
`default_nettype none

module overrange_hold (
  input wire logic clk,
  input wire logic reset,
  input wire logic [8:0] sample,
  input wire logic [8:0] threshold,
  input wire logic [7:0] min_pulse,
  output logic flag_q,
  output logic event_o
);

  logic exceed;
  logic [7:0] cnt_q;

  // ==========================================================
  // Detect and stretch
  assign exceed = sample > threshold;
  assign event_o = exceed && !flag_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 8'h00;
      flag_q <= 1'b0;
    end else if (exceed) begin
      cnt_q <= min_pulse;
      flag_q <= 1'b1;
    end else begin
      flag_q <= (cnt_q > 8'h01);
      if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ==========================================================
  // Checks
  property p_hold_stays;
    @(posedge clk) disable iff (reset)
    (!exceed && cnt_q > 8'h01) |=> flag_q;
  endproperty
  a_hold_stays: assert property (p_hold_stays) else $error("flag dropped early");

  property p_count_restart;
    @(posedge clk) disable iff (reset)
    exceed |=> (flag_q && cnt_q == $past(min_pulse));
  endproperty
  a_count_restart: assert property (p_count_restart) else $error("count not restarted");

endmodule : overrange_hold

`default_nettype wire

// ### design/overrange_map.svh
`ifndef OVERRANGE_MAP_SVH
`define OVERRANGE_MAP_SVH

// ==========================================================
// Register offsets
`define OFS_THRESHOLD 8'h00
`define OFS_MIN_PULSE 8'h04
`define OFS_CLOCK_CTRL 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_STATE 8'h14

// ==========================================================
// Field positions
`define CTRL_OVR_EN_BIT 0
`define CTRL_C_SEL_LO 1
`define CTRL_C_SEL_HI 2
`define CTRL_D_SEL_LO 3
`define CTRL_D_SEL_HI 4
`define STATE_FLAGS_LO 0
`define STATE_FLAGS_HI 3
`define STATE_SEL_LO 4
`define STATE_SEL_HI 5
`define STATE_C_CLK_BIT 6
`define STATE_D_CLK_BIT 7
`define STATE_VAR_LO 8
`define STATE_VAR_HI 9

// ==========================================================
// Reset values
`define RST_THRESHOLD 9'h1FF
`define RST_MIN_PULSE 8'h01
`define RST_CLOCK_CTRL 5'h00
`define RST_IRQ_MASK 4'h0

`endif

// ### design/overrange_pkg.sv
package overrange_pkg;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    sel_off = 2'b00,
    sel_ref = 2'b01,
    sel_div2 = 2'b10,
    sel_div4 = 2'b11
  } clock_sel_t;

  typedef enum logic [1:0] {
    variant_quad = 2'b00,
    variant_dual = 2'b01,
    variant_single = 2'b10,
    variant_spare = 2'b11
  } variant_t;

  typedef struct packed {
    logic [8:0] a;
    logic [8:0] b;
    logic [8:0] c;
    logic [8:0] d;
  } chan_samples_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : overrange_pkg

// ### design/ref_clock_div.sv
`timescale 1ns/100ps
`default_nettype none

module ref_clock_div (
  input wire logic clk,
  input wire logic reset,
  input wire logic ref_in,
  output logic ref_q,
  output logic div2_q,
  output logic div4_q
);

  logic [1:0] cnt_q;
  logic rise;

  // ==========================================================
  // Edge count
  assign rise = ref_in && !ref_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 2'h0;
    end else if (rise) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign div2_q = cnt_q[0];
  assign div4_q = cnt_q[1];

  // ==========================================================
  // Checks
  property p_div_steady;
    @(posedge clk) disable iff (reset)
    !rise |=> ($stable(div2_q) && $stable(div4_q));
  endproperty
  a_div_steady: assert property (p_div_steady) else $error("divider moved without edge");

endmodule : ref_clock_div

`default_nettype wire

// ### tb/or_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Board-side monitor of flag and clock pins
module or_monitor (
  input wire logic clk,
  input wire logic clear,
  input wire logic [3:0] pins,
  output logic [3:0][15:0] high_cnt,
  output logic [15:0] c_edges,
  output logic [15:0] d_edges
);
  logic [3:0] prev_q;

  always_ff @(posedge clk) begin
    prev_q <= pins;
    if (clear) begin
      high_cnt <= '0;
      c_edges <= 16'h0;
      d_edges <= 16'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        high_cnt[i] <= high_cnt[i] + 16'(pins[i]);
      end
      c_edges <= c_edges + 16'(pins[2] & ~prev_q[2]);
      d_edges <= d_edges + 16'(pins[3] & ~prev_q[3]);
    end
  end
endmodule : or_monitor

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  overrange_pkg::chan_samples_t samples = '0;
  logic [1:0] ref_div_q = 2'h0;
  logic synth_enable_pin = 1'b0;
  logic power_down_pin = 1'b0;
  logic [1:0] clock_out_select_straps = 2'h0;
  logic [1:0] variant_straps = 2'h0;
  overrange_pkg::reg_req_t reg_req = '0;
  logic [31:0] rd_data_q;
  logic irq_q;
  wire [3:0] pins;
  logic clear = 1'b0;
  logic [3:0][15:0] high_cnt;
  logic [15:0] c_edges;
  logic [15:0] d_edges;
  int n_mismatch = 0;
  int samples_checked = 0;

  // ==========================================================
  // Clocks and instances
  always #25 clk = ~clk;
  always @(posedge clk) ref_div_q <= ref_div_q + 2'h1;

  overrange_clock_out_mux overrange_clock_out_mux_i (
    .clk(clk),
    .reset(reset),
    .samples(samples),
    .synth_ref_clock_out(ref_div_q[1]),
    .synth_enable_pin(synth_enable_pin),
    .power_down_pin(power_down_pin),
    .clock_out_select_straps(clock_out_select_straps),
    .variant_straps(variant_straps),
    .reg_req(reg_req),
    .rd_data_q(rd_data_q),
    .irq_q(irq_q),
    .overrange_out_chan_a(pins[0]),
    .overrange_out_chan_b(pins[1]),
    .overrange_or_clock_out_c(pins[2]),
    .overrange_or_clock_out_d(pins[3])
  );

  or_monitor or_monitor_i (
    .clk(clk),
    .clear(clear),
    .pins(pins),
    .high_cnt(high_cnt),
    .c_edges(c_edges),
    .d_edges(d_edges)
  );

  // ==========================================================
  // Tasks
  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (!(got === exp || got === exp + 16'h1 || got === exp - 16'h1)) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    chk_val(rd_data_q, exp);
  endtask : reg_check

  task automatic do_reset(input logic [1:0] v, input logic [1:0] s, input logic en);
    @(posedge clk);
    reset <= 1'b1;
    variant_straps <= v;
    clock_out_select_straps <= s;
    synth_enable_pin <= en;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset

  task automatic clr_mon();
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
  endtask : clr_mon

  // Exceed on all channels, a second time after gap cycles if gap > 0
  task automatic pulse(input logic [8:0] v, input int gap);
    clr_mon();
    samples <= {4{v}};
    @(posedge clk);
    samples <= '0;
    if (gap > 0) begin
      repeat (gap - 1) @(posedge clk);
      samples <= {4{v}};
      @(posedge clk);
      samples <= '0;
    end
    repeat (300) @(posedge clk);
    #1;
  endtask : pulse

  task automatic flags(input logic [3:0] m, input logic [15:0] n);
    for (int i = 0; i < 4; i++) begin
      chk_val({16'h0, high_cnt[i]}, m[i] ? {16'h0, n} : 32'h0);
    end
  endtask : flags

  task automatic clk_chk(input logic [15:0] ec, input logic [15:0] ed);
    repeat (20) @(posedge clk);
    clr_mon();
    repeat (160) @(posedge clk);
    #1;
    chk_cnt(c_edges, ec);
    chk_cnt(d_edges, ed);
  endtask : clk_chk

  // ==========================================================
  // Tests
  initial begin
    do_reset(2'h0, 2'h0, 1'b0);
    reg_check(8'h00, 32'h1FF);
    reg_check(8'h04, 32'h1);
    reg_check(8'h08, 32'h0);
    reg_check(8'h10, 32'h0);
    reg_check(8'h3C, 32'h0);
    reg_write(8'h00, 32'h100);
    reg_check(8'h00, 32'h100);
    reg_write(8'h04, 32'h5);
    pulse(9'h101, 0);
    flags(4'hF, 16'h5);
    pulse(9'h100, 0);
    flags(4'hF, 16'h0);
    pulse(9'h101, 3);
    flags(4'hF, 16'h8);
    reg_write(8'h04, 32'h1);
    pulse(9'h101, 0);
    flags(4'hF, 16'h1);
    chk_val({31'h0, irq_q}, 32'h0);
    reg_check(8'h0C, 32'hF);
    reg_check(8'h0C, 32'h0);
    reg_write(8'h10, 32'h1);
    pulse(9'h101, 0);
    chk_val({31'h0, irq_q}, 32'h1);
    reg_check(8'h0C, 32'hF);
    chk_val({31'h0, irq_q}, 32'h0);
    for (int v = 1; v < 4; v++) begin
      do_reset(2'(v), 2'h0, 1'b0);
      reg_write(8'h00, 32'h100);
      pulse(9'h101, 0);
      flags(v == 1 ? 4'h3 : 4'h1, 16'h1);
      reg_check(8'h14, 32'(v) << 8);
    end
    for (int s = 1; s < 4; s++) begin
      do_reset(2'h0, 2'(s), 1'b1);
      clk_chk(16'h28 >> (s - 1), 16'h28);
    end
    do_reset(2'h0, 2'h1, 1'b0);
    clk_chk(16'h0, 16'h0);
    reg_write(8'h00, 32'h100);
    pulse(9'h101, 0);
    flags(4'hF, 16'h1);
    do_reset(2'h0, 2'h1, 1'b1);
    power_down_pin <= 1'b1;
    clk_chk(16'h0, 16'h0);
    @(posedge clk);
    power_down_pin <= 1'b0;
    do_reset(2'h0, 2'h0, 1'b1);
    for (int s = 1; s < 4; s++) begin
      reg_write(8'h08, 32'(s * 2 + 1));
      clk_chk(16'h28 >> (s - 1), 16'h0);
    end
    reg_write(8'h08, 32'h9);
    clk_chk(16'h0, 16'h0);
    reg_write(8'h08, 32'hB);
    clk_chk(16'h28, 16'h28);
    reg_check(8'h08, 32'hB);
    reg_check(8'h14, 32'hD0);
    reg_write(8'h08, 32'h1F);
    clk_chk(16'hA, 16'hA);
    test_done();
  end

  initial begin
    #1000000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_top

`default_nettype wire
